/* hdl/rtc_pkg.sv */
// shared constants for the real-time clock serial slave and its seconds pre-scaler
package rtc_pkg;

  // serial slave addressing
  localparam logic [6:0] SLAVE_ADDR      = 7'h2A;
  localparam int         REG_AW          = 4;
  localparam int         REG_COUNT       = 16;
  localparam logic [3:0] REG_CTRL1       = 4'h0;
  localparam logic [3:0] REG_SECONDS     = 4'h2;

  // first control/status register fields
  localparam int         CTRL1_TEST_BIT   = 7;
  localparam int         CTRL1_HOLD_BIT   = 5;
  localparam int         CTRL1_PERMIT_BIT = 3;
  localparam logic [7:0] CTRL1_RESET      = 8'h08;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // seconds register, packed decimal
  localparam logic [3:0] BCD_UNITS_MAX   = 4'h9;
  localparam logic [2:0] BCD_TENS_MAX    = 3'h5;

  // byte framing
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [2:0] LAST_TX_BIT     = 3'h7;

  // time keeping
  localparam int         SYS_CLK_HZ       = 50_000_000;
  localparam int         TICK_HZ          = 64;
  localparam int         TICK_HALF_CYCLES = SYS_CLK_HZ / (2 * TICK_HZ);
  localparam int         PRESCALE_W       = 6;
  localparam logic [5:0] PRESCALE_SECOND  = 6'h20;

  // internal power-on reset hold, in link clock cycles
  localparam int         POR_CYCLES      = 100_000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100
  } slave_state_t;

  typedef enum logic [1:0] {
    BYTE_ADDR = 2'b00,
    BYTE_WORD = 2'b01,
    BYTE_DATA = 2'b10
  } byte_kind_t;

endpackage

/* hdl/tick_if.sv */
// carrier between the serial slave domain and the seconds pre-scaler domain
`timescale 1ns/10ps
interface tick_if;
  logic test_en;
  logic hold;
  logic sec_tgl;

  modport link_side (output test_en, output hold, input sec_tgl);
  modport time_side (input test_en, input hold, output sec_tgl);
endinterface

/* hdl/tick_prescaler.sv */
// 64 Hz tick source, external tick selection and six-stage seconds pre-scaler
`timescale 1ns/10ps
module tick_prescaler #(
  parameter int TICK_HALF = rtc_pkg::TICK_HALF_CYCLES
) (
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire logic     clock_output_pin_i,
  tick_if.time_side     tif,
  output logic          clock_output_pin_o,
  output logic          clock_output_pin_oe
);

  localparam int DIV_W = (TICK_HALF > 1) ? $clog2(TICK_HALF) : 1;

  logic                          test_meta;
  logic                          test_sync;
  logic                          hold_meta;
  logic                          hold_sync;
  logic                          ext_meta;
  logic                          ext_sync;
  logic                          ext_prev;
  logic [DIV_W-1:0]              div_cnt;
  logic                          tick_lvl;
  logic                          tick_prev;
  logic [rtc_pkg::PRESCALE_W-1:0] presc;
  logic                          sec_tgl;
  logic                          src_rise;

  // level crossings from the link domain and the pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      test_meta <= 1'b0;
      test_sync <= 1'b0;
      hold_meta <= 1'b0;
      hold_sync <= 1'b0;
      ext_meta  <= 1'b1;
      ext_sync  <= 1'b1;
      ext_prev  <= 1'b1;
    end else begin
      test_meta <= tif.test_en;
      test_sync <= test_meta;
      hold_meta <= tif.hold;
      hold_sync <= hold_meta;
      ext_meta  <= clock_output_pin_i;
      ext_sync  <= ext_meta;
      ext_prev  <= ext_sync;
    end
  end

  // internal 64 Hz square wave
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt   <= '0;
      tick_lvl  <= 1'b0;
      tick_prev <= 1'b0;
    end else begin
      tick_prev <= tick_lvl;
      if (div_cnt == DIV_W'(TICK_HALF - 1)) begin
        div_cnt  <= '0;
        tick_lvl <= ~tick_lvl;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  assign src_rise = test_sync ? (ext_sync & ~ext_prev)   // R2
                              : (tick_lvl & ~tick_prev);

  // pre-scaler; a second is flagged as the chain passes its half-way point
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      presc   <= '0;
      sec_tgl <= 1'b0;
    end else if (hold_sync) begin
      presc <= '0;                                         // R4
    end else if (src_rise) begin
      presc <= presc + 1'b1;                               // R3
      if (presc + 1'b1 == rtc_pkg::PRESCALE_SECOND) begin
        sec_tgl <= ~sec_tgl;                               // R5
      end
    end
  end

  assign tif.sec_tgl = sec_tgl;

  // pin drives the tick out in normal mode, turns into an input in test mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_output_pin_o  <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else begin
      clock_output_pin_o  <= 1'b0;
      clock_output_pin_oe <= ~test_sync & ~tick_lvl;                 // R1
    end
  end

endmodule

/* hdl/rtc_serial_slave.sv */
// two-wire serial slave with register file, test mode and power-on reset override
`timescale 1ns/10ps
// Functional notes
// R1 - test enable bit turns clock pin into input
// R2 - test mode: pin edges replace internal tick
// R3 - six-stage pre-scaler divides tick to seconds
// R4 - hold bit forces pre-scaler to zero
// R5 - first second after 32, then every 64
// R6 - tester uses hold bit for known state
// R7 - override sequence releases internal reset immediately
// R8 - writing permit zero clears override mode
// R9 - permit zero otherwise only blocks override entry
// R10 - master starts only on idle bus
// R11 - start and stop seen with clock high
// R12 - data changes only while clock low
// R13 - eight bits plus acknowledge per byte
// R14 - acknowledge received bytes by pulling data low
// R15 - no master acknowledge: release data line
// R16 - first byte after start is address
// R17 - clock input only, data bidirectional
// R18 - only low word address nibble used
// R19 - pointer increments after each data byte
// R20 - fixed address, direction bit selects read
module rtc_serial_slave #(
  parameter int TICK_HALF  = rtc_pkg::TICK_HALF_CYCLES,
  parameter int POR_CYCLES = rtc_pkg::POR_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic link_clk,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic clock_output_pin_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      clock_output_pin_o,
  output logic      clock_output_pin_oe,
  output logic      internal_reset_active
);

  localparam int POR_W = (POR_CYCLES > 1) ? $clog2(POR_CYCLES) : 1;

  tick_if tif ();

  tick_prescaler #(
    .TICK_HALF (TICK_HALF)
  ) u_prescaler (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clock_output_pin_i  (clock_output_pin_i),
    .tif       (tif),
    .clock_output_pin_o  (clock_output_pin_o),
    .clock_output_pin_oe (clock_output_pin_oe)
  );

  logic                       link_rst_meta;
  logic                       link_rst;
  logic                       scl_meta;
  logic                       scl_sync;
  logic                       scl_prev;
  logic                       sda_meta;
  logic                       sda_sync;
  logic                       sda_prev;
  logic                       sec_meta;
  logic                       sec_sync;
  logic                       sec_prev;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_cond;
  logic                       stop_cond;
  logic                       sec_inc;
  logic [POR_W-1:0]           por_cnt;
  logic                       por_active;
  logic                       seq_armed;
  logic                       override_hit;
  logic                       override_mode;
  rtc_pkg::slave_state_t      state;
  rtc_pkg::byte_kind_t        byte_kind;
  logic                       rw;
  logic                       ack_seen;
  logic [3:0]                 bit_cnt;
  logic [7:0]                 rx_shift;
  logic [7:0]                 tx_shift;
  logic [rtc_pkg::REG_AW-1:0] ptr;
  logic [7:0]                 regs [rtc_pkg::REG_COUNT];
  logic                       byte_done;
  logic                       addr_match;
  logic                       data_wr;
  logic                       tx_done;
  logic                       permit_clear;

  // reset and pin synchronisers into the link domain
  always_ff @(posedge link_clk) begin
    link_rst_meta <= rst;
    link_rst      <= link_rst_meta;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_i;                                   // R17
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // seconds event arrives as a toggle from the pre-scaler domain
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sec_meta <= 1'b0;
      sec_sync <= 1'b0;
      sec_prev <= 1'b0;
    end else begin
      sec_meta <= tif.sec_tgl;
      sec_sync <= sec_meta;
      sec_prev <= sec_sync;
    end
  end

  // both pins share the same synchroniser depth, so start and stop
  // are judged on samples that cannot skew against each other
  assign sec_inc    = sec_sync ^ sec_prev;
  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;   // R11
  assign stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;   // R11

  assign byte_done  = (state == rtc_pkg::ST_RX) & scl_fall
                      & (bit_cnt == rtc_pkg::BITS_PER_BYTE);        // R13
  assign addr_match = (rx_shift[7:1] == rtc_pkg::SLAVE_ADDR);       // R20
  assign data_wr    = byte_done & (byte_kind == rtc_pkg::BYTE_DATA);
  assign tx_done    = (state == rtc_pkg::ST_TX) & scl_fall
                      & (bit_cnt[2:0] == rtc_pkg::LAST_TX_BIT);
  assign permit_clear = data_wr & (ptr == rtc_pkg::REG_CTRL1)
                        & ~rx_shift[rtc_pkg::CTRL1_PERMIT_BIT];

  // internal power-on reset, cut short by the override sequence
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      por_cnt    <= '0;
      por_active <= 1'b1;
    end else if (por_active) begin
      if (override_hit) begin
        por_active <= 1'b0;                                // R7
      end else if (por_cnt == POR_W'(POR_CYCLES - 1)) begin
        por_active <= 1'b0;
      end else begin
        por_cnt <= por_cnt + 1'b1;
      end
    end
  end

  // override sequence: a start followed by a stop with no clock low between
  assign override_hit = seq_armed & stop_cond;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      seq_armed <= 1'b0;
    end else if (!por_active || scl_fall) begin
      seq_armed <= 1'b0;
    end else if (start_cond) begin
      seq_armed <= regs[rtc_pkg::REG_CTRL1][rtc_pkg::CTRL1_PERMIT_BIT];   // R9
    end
  end

  // a same-cycle clear loses to the override hit;
  // clearing never re-asserts the internal reset
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      override_mode <= 1'b0;
    end else if (override_hit) begin
      override_mode <= 1'b1;
    end else if (permit_clear) begin
      override_mode <= 1'b0;                               // R8
    end
  end

  // registered copy, so the port comes straight from a flip-flop
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      internal_reset_active <= 1'b1;
    end else begin
      internal_reset_active <= por_active;
    end
  end

  // bit receiver, msb first, sampled on the rising clock
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rx_shift <= 8'h00;
    end else if (state == rtc_pkg::ST_RX && scl_rise) begin
      rx_shift <= {rx_shift[6:0], sda_sync};               // R12
    end
  end

  // master acknowledge after a transmitted byte, sampled on the ninth
  // rising clock; a released line ends the read
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ack_seen <= 1'b0;
    end else if (state == rtc_pkg::ST_TX_ACK && scl_rise) begin
      ack_seen <= ~sda_sync;
    end
  end

  // word address pointer; upper nibble of the address byte is dropped
  // and the pointer wraps from the last register back to the first
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ptr <= '0;
    end else if (byte_done && byte_kind == rtc_pkg::BYTE_WORD && !rw) begin
      ptr <= rx_shift[rtc_pkg::REG_AW-1:0];                // R18
    end else if (data_wr || tx_done) begin
      ptr <= ptr + 1'b1;                                   // R19
    end
  end

  // register file; a bus write to seconds wins over a same-cycle tick
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      for (int i = 0; i < rtc_pkg::REG_COUNT; i++) begin
        regs[i] <= rtc_pkg::REG_RESET;
      end
      regs[rtc_pkg::REG_CTRL1] <= rtc_pkg::CTRL1_RESET;
    end else begin
      if (data_wr) begin
        regs[ptr] <= rx_shift;
      end
      if (sec_inc && !(data_wr && ptr == rtc_pkg::REG_SECONDS)) begin
        if (regs[rtc_pkg::REG_SECONDS][3:0] != rtc_pkg::BCD_UNITS_MAX) begin
          regs[rtc_pkg::REG_SECONDS][3:0] <= regs[rtc_pkg::REG_SECONDS][3:0] + 1'b1;
        end else begin
          regs[rtc_pkg::REG_SECONDS][3:0] <= 4'h0;
          if (regs[rtc_pkg::REG_SECONDS][6:4] != rtc_pkg::BCD_TENS_MAX) begin
            regs[rtc_pkg::REG_SECONDS][6:4] <= regs[rtc_pkg::REG_SECONDS][6:4] + 1'b1;
          end else begin
            regs[rtc_pkg::REG_SECONDS][6:4] <= 3'h0;
          end
        end
      end
    end
  end

  assign tif.test_en = regs[rtc_pkg::REG_CTRL1][rtc_pkg::CTRL1_TEST_BIT];   // R1
  assign tif.hold    = regs[rtc_pkg::REG_CTRL1][rtc_pkg::CTRL1_HOLD_BIT];   // R4

  // byte-level slave sequencer; start and stop win over every state,
  // and transmit bits are set up on the falling clock ahead of the sample
  always_ff @(posedge link_clk) begin
    if (link_rst || por_active) begin
      state     <= rtc_pkg::ST_IDLE;
      byte_kind <= rtc_pkg::BYTE_ADDR;
      rw        <= 1'b0;
      bit_cnt   <= 4'h0;
      tx_shift  <= 8'h00;
      sda_oe    <= 1'b0;
    end else if (start_cond) begin
      state     <= rtc_pkg::ST_RX;
      byte_kind <= rtc_pkg::BYTE_ADDR;                     // R16
      bit_cnt   <= 4'h0;
      sda_oe    <= 1'b0;
    end else if (stop_cond) begin
      state  <= rtc_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        rtc_pkg::ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        rtc_pkg::ST_RX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
          end else if (byte_done) begin
            if (byte_kind == rtc_pkg::BYTE_ADDR && !addr_match) begin
              state <= rtc_pkg::ST_IDLE;
            end else begin
              state  <= rtc_pkg::ST_RX_ACK;
              sda_oe <= 1'b1;                              // R14
              if (byte_kind == rtc_pkg::BYTE_ADDR) begin
                rw <= rx_shift[0];                         // R20
              end
            end
          end
        end
        rtc_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (byte_kind == rtc_pkg::BYTE_ADDR && rw) begin
              state    <= rtc_pkg::ST_TX;
              tx_shift <= regs[ptr];
              sda_oe   <= ~regs[ptr][7];
            end else begin
              state     <= rtc_pkg::ST_RX;
              sda_oe    <= 1'b0;
              byte_kind <= (byte_kind == rtc_pkg::BYTE_ADDR) ? rtc_pkg::BYTE_WORD
                                                             : rtc_pkg::BYTE_DATA;
            end
          end
        end
        rtc_pkg::ST_TX: begin
          if (tx_done) begin
            state  <= rtc_pkg::ST_TX_ACK;
            sda_oe <= 1'b0;
          end else if (scl_fall) begin
            bit_cnt  <= bit_cnt + 1'b1;
            tx_shift <= {tx_shift[6:0], 1'b0};
            sda_oe   <= ~tx_shift[6];                      // R12
          end
        end
        rtc_pkg::ST_TX_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (ack_seen) begin
              state    <= rtc_pkg::ST_TX;
              tx_shift <= regs[ptr];
              sda_oe   <= ~regs[ptr][7];
            end else begin
              state  <= rtc_pkg::ST_IDLE;
              sda_oe <= 1'b0;                              // R15
            end
          end
        end
        default: begin
          state  <= rtc_pkg::ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data: only ever pulls low
  // the enable alone decides the line level
  always_ff @(posedge link_clk) begin
    sda_o <= 1'b0;
  end

endmodule

/* sim/rtc_serial_slave_properties.sv */
// concurrent checks on the serial slave top ports
`timescale 1ns/10ps
module rtc_serial_slave_properties #(
  parameter int TICK_HALF  = 4,
  parameter int POR_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic clock_output_pin_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic clock_output_pin_o,
  input wire logic clock_output_pin_oe,
  input wire logic internal_reset_active
);
  logic [31:0] hi_cnt;

  // length of the current driven half of the tick output
  always_ff @(posedge sys_clk) begin
    if (rst || !clock_output_pin_oe) begin
      hi_cnt <= 32'h0;
    end else begin
      hi_cnt <= hi_cnt + 32'h1;
    end
  end

  sequence s_scl_rise;
    $rose(scl_i);
  endsequence
  sequence s_scl_high;
    scl_i [*4];
  endsequence

  property p_ack_hold;
    @(posedge link_clk) disable iff (rst) sda_oe ##0 s_scl_rise |-> sda_oe throughout s_scl_high;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data let go in clock high");
  property p_sda_change;
    @(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl_i;
  endproperty
  a_sda_change: assert property (p_sda_change) else $error("data moved in clock high");
  property p_sda_o_zero;
    @(posedge link_clk) disable iff (rst) sda_o == 1'b0;
  endproperty
  a_sda_o_zero: assert property (p_sda_o_zero) else $error("data pin driven high");
  property p_por_quiet;
    @(posedge link_clk) disable iff (rst) internal_reset_active |-> !sda_oe;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("bus answered in reset");
  property p_rst_quiet;
    @(posedge link_clk) rst [*4] |-> internal_reset_active && !sda_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("slave live in reset");
  property p_rst_clock_output_pin;
    @(posedge sys_clk) rst |=> !clock_output_pin_oe;
  endproperty
  a_rst_clock_output_pin: assert property (p_rst_clock_output_pin) else $error("tick pin driven in reset");
  property p_clock_output_pin_o_zero;
    @(posedge sys_clk) disable iff (rst) clock_output_pin_o == 1'b0;
  endproperty
  a_clock_output_pin_o_zero: assert property (p_clock_output_pin_o_zero) else $error("tick pin high");
  property p_clock_output_pin_half;
    @(posedge sys_clk) disable iff (rst) hi_cnt <= 32'(TICK_HALF);
  endproperty
  a_clock_output_pin_half: assert property (p_clock_output_pin_half) else $error("tick half too long");
endmodule

bind rtc_serial_slave rtc_serial_slave_properties #(
  .TICK_HALF (TICK_HALF),
  .POR_CYCLES(POR_CYCLES)
) u_props (
  .sys_clk              (sys_clk),
  .rst                  (rst),
  .link_clk             (link_clk),
  .scl_i                (scl_i),
  .sda_i                (sda_i),
  .clock_output_pin_i             (clock_output_pin_i),
  .sda_o                (sda_o),
  .sda_oe               (sda_oe),
  .clock_output_pin_o             (clock_output_pin_o),
  .clock_output_pin_oe            (clock_output_pin_oe),
  .internal_reset_active(internal_reset_active)
);

/* sim/i2c_master_model.sv */
// serial bus master model: drives the clock line, pulls the data line low
`timescale 1ns/10ps
module i2c_master_model (
  input  wire logic link_clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low,
  output logic      res_stb,
  output logic [8:0] res
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_stb = 1'b0;
    res = 9'h000;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge link_clk);
  endtask
  // data low and back with the clock held high throughout
  task automatic ovr();
    sda_low = 1'b1;
    wt(6);
    sda_low = 1'b0;
    wt(6);
  endtask
  task automatic start();
    sda_low = 1'b0;
    for (int n = 0; n < 64 && sda_in !== 1'b1; n++) wt(1);
    wt(6);
    scl = 1'b1;
    wt(6);
    sda_low = 1'b1;
    wt(6);
    scl = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    wt(6);
    scl = 1'b1;
    wt(6);
    sda_low = 1'b0;
    wt(6);
  endtask
  task automatic bit_x(input logic v, output logic got);
    sda_low = ~v;
    wt(6);
    scl = 1'b1;
    wt(6);
    got = sda_in;
    scl = 1'b0;
    wt(2);
  endtask
  task automatic byte_x(input logic [7:0] tx, input logic mack);
    logic [8:0] r;
    for (int i = 7; i >= 0; i--) bit_x(tx[i], r[i]);
    bit_x(mack, r[8]);
    res = r;
    res_stb = 1'b1;
    wt(1);
    res_stb = 1'b0;
  endtask
endmodule

/* sim/tb.sv */
// bench: serial register access, external tick test mode, reset override
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] AW = {rtc_pkg::SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR = {rtc_pkg::SLAVE_ADDR, 1'b1};
  logic       sys_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext_tick = 1'b1;
  logic       scl;
  logic       m_low;
  logic       res_stb;
  logic [8:0] res;
  logic       sda_o;
  logic       sda_oe;
  logic       clock_output_pin_o;
  logic       clock_output_pin_oe;
  logic       internal_reset_active;
  logic [9:0] nt;
  logic [7:0] r1;
  logic [4:0] k;
  logic [9:0] q[$];
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         cyc = 0;
  wire        sda_w = (sda_oe ? sda_o : 1'b1) & ~m_low;
  wire        ck_w = (clock_output_pin_oe ? clock_output_pin_o : 1'b1) & ext_tick;

  always #10 sys_clk = ~sys_clk;
  always #7.5 link_clk = ~link_clk;

  rtc_serial_slave #(.TICK_HALF(4), .POR_CYCLES(2000)) u_rtc_serial_slave (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .link_clk             (link_clk),
    .scl_i                (scl),
    .sda_i                (sda_w),
    .clock_output_pin_i             (ck_w),
    .sda_o                (sda_o),
    .sda_oe               (sda_oe),
    .clock_output_pin_o             (clock_output_pin_o),
    .clock_output_pin_oe            (clock_output_pin_oe),
    .internal_reset_active(internal_reset_active)
  );
  i2c_master_model u_i2c_master_model (
    .link_clk(link_clk),
    .sda_in  (sda_w),
    .scl     (scl),
    .sda_low (m_low),
    .res_stb (res_stb),
    .res     (res)
  );

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_bit(input logic e, input logic g);
    cmp({8'h00, e}, {8'h00, g});
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    cmp({1'b0, e}, {1'b0, g});
  endtask

  // oldest note against each finished byte
  always @(posedge link_clk) begin
    if (res_stb === 1'b1) begin
      if (q.size() == 0) begin
        cmp(9'h1FF, {1'b0, res[7:0]});
      end else begin
        nt = q.pop_front();
        if (nt[9]) begin
          cmp_byte(nt[7:0], res[7:0]);
        end else begin
          cmp_bit(nt[8], res[8]);
        end
      end
    end
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [7:0] b, input logic nak);
    q.push_back({1'b0, nak, b});
    u_i2c_master_model.byte_x(b, 1'b1);
  endtask
  task automatic rd(input logic [7:0] e, input logic nak);
    q.push_back({1'b1, nak, e});
    u_i2c_master_model.byte_x(8'hFF, nak);
  endtask
  task automatic point(input logic [3:0] w);
    u_i2c_master_model.start();
    wr(AW, 1'b0);
    wr({4'($urandom), w}, 1'b0);
  endtask
  task automatic regw(input logic [3:0] w, input logic [7:0] d);
    point(w);
    wr(d, 1'b0);
    u_i2c_master_model.stop();
  endtask
  task automatic secr(input logic [7:0] e);
    point(rtc_pkg::REG_SECONDS);
    u_i2c_master_model.start();
    wr(AR, 1'b0);
    rd(e, 1'b1);
    u_i2c_master_model.stop();
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      ext_tick = 1'b0;
      repeat (4) @(negedge sys_clk);
      ext_tick = 1'b1;
      repeat (3) @(negedge sys_clk);
    end
  endtask
  task automatic tick_out(input logic [4:0] e);
    k = 5'h00;
    repeat (16) begin
      @(negedge sys_clk);
      k = k + 5'(clock_output_pin_oe);
    end
    cmp_byte({3'h0, e}, {3'h0, k});
  endtask

  initial begin
    void'($urandom(34130));
    r1 = 8'($urandom);
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp_bit(1'b1, internal_reset_active);
    u_i2c_master_model.ovr();
    repeat (8) @(negedge link_clk);
    cmp_bit(1'b0, internal_reset_active);
    tick_out(5'h08);
    u_i2c_master_model.start();
    wr(8'hA4, 1'b1);
    u_i2c_master_model.stop();
    point(rtc_pkg::REG_CTRL1);
    wr(8'hA8, 1'b0);
    wr(r1, 1'b0);
    wr(8'h00, 1'b0);
    u_i2c_master_model.stop();
    tick_out(5'h00);
    ticks(40);
    regw(rtc_pkg::REG_CTRL1, 8'h88);
    ticks(31);
    secr(8'h00);
    ticks(1);
    secr(8'h01);
    ticks(64);
    point(4'h1);
    u_i2c_master_model.start();
    wr(AR, 1'b0);
    rd(r1, 1'b0);
    rd(8'h02, 1'b1);
    u_i2c_master_model.stop();
    regw(rtc_pkg::REG_CTRL1, 8'h80);
    ticks(64);
    secr(8'h03);
    regw(rtc_pkg::REG_CTRL1, 8'h00);
    tick_out(5'h08);
    repeat (10) @(negedge link_clk);
    cmp_bit(1'b1, q.size() == 0);
    report_and_stop();
  end
endmodule
